// ==== core/twal_unit.v ====
/*
 * Decode, check and execute logic for the alternate-space twin-word
 * load, with a classic Wishbone register slave and one interrupt.
 * Assumes the pipeline presents the instruction with its source
 * operands, space register and privilege bit in the same cycle, and
 * that the memory path returns both words in one indivisible access.
 */
`timescale 1ns/1ps
`include "twal_regs.vh"

// Behaviour
// - Opcode subfield 01 0011 selects this path
// - Word at EA to even, EA+4 to odd
// - Upper 32 bits of both registers cleared
// - Destination zero writes only register one
// - Select bit 0: field space, rs1+rs2
// - Select bit 1: space register, rs1+imm
// - Little-endian spaces swap each word separately
// - Without hardware support, always unimplemented trap
// - Odd destination raises illegal instruction trap
// - Non-doubleword-aligned address raises misaligned trap
// - Both words fetched in one atomic access
// - User mode, space bit 7 clear: privilege trap
// - Privileged, space 30..7F: privilege trap
// - Only listed spaces valid, else data trap
// - Space 24 aliases twin-extended nucleus 27
// - Twin-extended space with select 0 redirects
// - Nontranslating spaces raise data access trap
module twal_unit #(
	parameter HW_IMPL = 1,
	parameter NUM_SPACES = 18,
	// Valid spaces, entry k at bits 8k+7:8k; defaults are plain choices
	parameter [NUM_SPACES*8-1:0] SPACE_LIST = {
		8'h89, 8'h88, 8'h83, 8'h82, 8'h8B, 8'h8A,
		8'h81, 8'h80, 8'h1D, 8'h15, 8'h1C, 8'h14,
		8'h19, 8'h18, 8'h11, 8'h10, 8'h0C, 8'h04},
	// One flag per entry of the list above: entry is little-endian
	parameter [NUM_SPACES-1:0] SPACE_LE = 18'h2AAAA
) (
	input wire clk_i,
	input wire rst_i,
	// Pipeline issue side
	input wire issue_valid_i,
	input wire [31:0] instr_i,
	input wire [63:0] src1_val_i,
	input wire [63:0] src2_val_i,
	input wire [7:0] space_reg_i,
	input wire privilege_state_bit_i,
	output wire issue_ready_o,
	output wire twin_match_o,
	output wire [4:0] first_source_field_o,
	output wire [4:0] second_source_field_o,
	// Memory path
	output reg mem_req_o,
	output reg mem_atomic_o,
	output reg [63:0] mem_addr_o,
	output reg [7:0] mem_space_o,
	input wire mem_ack_i,
	input wire mem_err_i,
	input wire [63:0] mem_rdata_i,
	// Register write-back
	output reg wb_even_we_o,
	output reg [4:0] wb_even_idx_o,
	output reg [63:0] wb_even_data_o,
	output reg wb_odd_we_o,
	output reg [4:0] wb_odd_idx_o,
	output reg [63:0] wb_odd_data_o,
	// Trap report
	output reg trap_valid_o,
	output reg [2:0] trap_code_o,
	// Redirect to the twin-extended load
	output reg redir_valid_o,
	output reg [63:0] redir_addr_o,
	output reg [7:0] redir_space_o,
	output reg [4:0] redir_rd_o,
	// Classic Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output wire irq_o
);

	// Two states suffice: the unit keeps at most one access outstanding,
	// which is what keeps the pair of words one indivisible read
	localparam S_IDLE = 1'b0; // Ready for a new instruction
	localparam S_MEM = 1'b1; // Waiting for the memory path

	// State held across cycles
	reg state_q; // Execution state
	reg [4:0] rd_q; // Even destination of the load in flight
	reg le_q; // Load in flight uses little-endian space
	reg enable_q; // Software enable of the hardware path
	reg [`TWAL_EVT_W-1:0] status_q; // Sticky events
	reg [`TWAL_EVT_W-1:0] mask_q; // Interrupt mask
	// Wraps silently; software reads differences, not absolute values
	reg [31:0] count_q; // Completed loads
	reg [`TWAL_EVT_W-1:0] evt; // Events of this cycle

	// Instruction fields
	// Decoded combinationally from the word presented with the issue
	wire [1:0] op = instr_i[`TWAL_OP_HI:`TWAL_OP_LO];
	wire [5:0] opcode_subfield = instr_i[`TWAL_OP3_HI:`TWAL_OP3_LO];
	wire [4:0] rd = instr_i[`TWAL_RD_HI:`TWAL_RD_LO];
	wire imm_sel = instr_i[`TWAL_IBIT];
	wire [7:0] imm_space = instr_i[`TWAL_ASI_HI:`TWAL_ASI_LO];
	// Offset overlaps the space field; the select bit says which one counts
	wire [12:0] signed_offset_immediate = instr_i[`TWAL_IMM_HI:`TWAL_IMM_LO];

	assign twin_match_o = (op == `TWAL_OP_MEM) && (opcode_subfield == `TWAL_OP3_TWIN);
	assign first_source_field_o = instr_i[`TWAL_RS1_HI:`TWAL_RS1_LO];
	assign second_source_field_o = instr_i[`TWAL_RS2_HI:`TWAL_RS2_LO];
	// A new instruction waits while a memory access is outstanding;
	// trap and redirect answers need no memory, so those issue back to back
	assign issue_ready_o = (state_q == S_IDLE);

	// Instruction accepted on this edge
	wire take = issue_valid_i && twin_match_o && issue_ready_o;

	// Field space and register-pair address when select is 0
	// Space register and sign-extended offset when select is 1
	wire [63:0] imm_ext = {{51{signed_offset_immediate[`TWAL_IMM_SIGN]}}, signed_offset_immediate};
	wire [7:0] space_raw = imm_sel ? space_reg_i : imm_space;
	// The sum wraps at 64 bits like any address add
	wire [63:0] eff_addr = src1_val_i + (imm_sel ? imm_ext : src2_val_i);

	// Alias folds onto the twin-extended nucleus space
	// Folding early lets every later check see a single code
	wire [7:0] space = (space_raw == `TWAL_TWINX_ALIAS) ? `TWAL_TWINX_N : space_raw;

	// Twin-extended space identifiers; their little-endian forms are not
	// accepted by this load and fall through to the data access trap
	wire is_twinx = (space == `TWAL_TWINX_AIUP) || (space == `TWAL_TWINX_AIUS) ||
		(space == `TWAL_TWINX_REAL) || (space == `TWAL_TWINX_N) ||
		(space == `TWAL_TWINX_P) || (space == `TWAL_TWINX_S);

	// Compare against each listed space
	// One comparator per entry; the list is a parameter so it can be trimmed
	wire [NUM_SPACES-1:0] hit;
	genvar g;
	generate
		for (g = 0; g < NUM_SPACES; g = g + 1) begin : g_space
			assign hit[g] = (space == SPACE_LIST[g*8 +: 8]);
		end
	endgenerate

	// Nontranslating spaces are not listed, so they trap
	wire space_ok = (|hit) || is_twinx;
	// Little-endian flag of the matching entry
	wire space_le = |(hit & SPACE_LE);

	// Privilege checks on the selected space
	// Bit 7 clear marks a restricted space in user mode
	wire priv_bad = privilege_state_bit_i ?
		((space >= `TWAL_ASI_PRIV_LO) && (space <= `TWAL_ASI_PRIV_HI)) :
		!space[`TWAL_ASI_UNRESTR_BIT];

	// Doubleword alignment
	// The low three address bits must all be zero
	wire misaligned = |eff_addr[`TWAL_ALIGN_BITS-1:0];

	// Select bit 0 with a twin-extended space goes elsewhere
	// The alias is folded first, so its code redirects as well
	wire redirect = is_twinx && !imm_sel;

	// Trap selection in priority order; the hardware path can be
	// switched off by software to force emulation
	// Priority: unimplemented, destination, privilege, space, alignment
	reg [2:0] trap_sel;
	always @* begin
		trap_sel = `TWAL_TRAP_NONE;
		if (HW_IMPL == 0 || !enable_q) begin
			trap_sel = `TWAL_TRAP_UNIMPL;
		end else if (rd[0]) begin
			trap_sel = `TWAL_TRAP_ILLEGAL;
		// Space not open to the current mode
		end else if (priv_bad) begin
			trap_sel = `TWAL_TRAP_PRIV;
		// Space not listed for this load
		end else if (!space_ok || (is_twinx && imm_sel)) begin
			// Select 1 with a twin-extended space is undefined; trapping is the safe answer
			trap_sel = `TWAL_TRAP_DACCESS;
		end else if (misaligned && !redirect) begin
			// The redirected load checks its own wider alignment
			trap_sel = `TWAL_TRAP_MISALIGN;
		end
	end

	// Byte swap within one 32-bit word
	// The lowest-addressed byte moves to bits 7:0
	function [31:0] swap32;
		input [31:0] w;
		begin
			swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
		end
	endfunction

	// Lower address word sits in the high half of the memory data,
	// so the even register always gets the lower address
	wire [31:0] word_lo_addr = mem_rdata_i[63:32];
	wire [31:0] word_hi_addr = mem_rdata_i[31:0];
	// Memory answer for the access in flight
	wire fin = (state_q == S_MEM) && mem_ack_i;

	// Execution state machine and memory request
	// Address and space are captured so they stay stable while memory stalls
	always @(posedge clk_i) begin
		if (rst_i) begin
			// No access outstanding after reset
			state_q <= S_IDLE;
			mem_req_o <= 1'b0;
			mem_atomic_o <= 1'b0;
			mem_addr_o <= 64'h0;
			mem_space_o <= 8'h00;
			rd_q <= 5'h00;
			le_q <= 1'b0;
		end else begin
			case (state_q)
				// Wait for an accepted load
				S_IDLE: begin
					// A trapped load never reaches memory
					if (take && trap_sel == `TWAL_TRAP_NONE && !redirect) begin
						state_q <= S_MEM;
						mem_req_o <= 1'b1;
						// Single locked access covers both words
						mem_atomic_o <= 1'b1;
						mem_addr_o <= eff_addr;
						mem_space_o <= space;
						rd_q <= rd;
						le_q <= space_le;
					end
				end
				// One access in flight; issue is stalled
				S_MEM: begin
					// Request holds until the memory path answers
					if (mem_ack_i) begin
						state_q <= S_IDLE;
						mem_req_o <= 1'b0;
						mem_atomic_o <= 1'b0;
					end
				end
				// Unused code: fall back to idle instead of hanging
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Write-back, trap and redirect outputs, one-cycle pulses
	always @(posedge clk_i) begin
		if (rst_i) begin
			// Pulses low, data and indices cleared
			wb_even_we_o <= 1'b0;
			wb_odd_we_o <= 1'b0;
			wb_even_idx_o <= 5'h00;
			wb_odd_idx_o <= 5'h00;
			wb_even_data_o <= 64'h0;
			wb_odd_data_o <= 64'h0;
			trap_valid_o <= 1'b0;
			trap_code_o <= `TWAL_TRAP_NONE;
			redir_valid_o <= 1'b0;
			redir_addr_o <= 64'h0;
			redir_space_o <= 8'h00;
			redir_rd_o <= 5'h00;
		end else begin
			// Each pulse falls unless set again below
			wb_even_we_o <= 1'b0;
			wb_odd_we_o <= 1'b0;
			trap_valid_o <= 1'b0;
			redir_valid_o <= 1'b0;
			// Trap report one cycle after the take
			if (take && trap_sel != `TWAL_TRAP_NONE) begin
				trap_valid_o <= 1'b1;
				trap_code_o <= trap_sel;
			// Handed over to the twin-extended load
			end else if (take && redirect) begin
				redir_valid_o <= 1'b1;
				redir_addr_o <= eff_addr;
				redir_space_o <= space;
				redir_rd_o <= rd;
			end
			// Memory answer: one cycle after the held request is met
			if (fin && mem_err_i) begin
				// Failed access leaves both registers untouched
				trap_valid_o <= 1'b1;
				trap_code_o <= `TWAL_TRAP_DACCESS;
			// Clean answer: write both halves of the pair, only the odd half when the destination is zero
			end else if (fin) begin
				wb_even_we_o <= (rd_q != 5'h00);
				wb_odd_we_o <= 1'b1;
				wb_even_idx_o <= rd_q;
				wb_odd_idx_o <= {rd_q[4:1], 1'b1};
				wb_even_data_o <= {32'h0, le_q ? swap32(word_lo_addr) : word_lo_addr};
				wb_odd_data_o <= {32'h0, le_q ? swap32(word_hi_addr) : word_hi_addr};
			end
		end
	end

	// Events of this cycle, one bit per status flag; the status
	// register below keeps them until software reads them
	always @* begin
		evt = {`TWAL_EVT_W{1'b0}};
		// Clean completion, trap of either kind, hand-over
		evt[`TWAL_EVT_DONE] = fin && !mem_err_i;
		evt[`TWAL_EVT_TRAP] = (take && trap_sel != `TWAL_TRAP_NONE) || (fin && mem_err_i);
		evt[`TWAL_EVT_REDIR] = take && trap_sel == `TWAL_TRAP_NONE && redirect;
	end

	// New request; the ack term keeps a held strobe from being served twice
	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes only use the lowest byte lane
	wire wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
	// Status read, which clears the sticky flags
	wire rd_status = bus_req && !wb_we_i && (wb_adr_i == `TWAL_REG_STATUS);

	// Register slave: answers every access one cycle after the strobe
	always @(posedge clk_i) begin
		if (rst_i) begin
			// Hardware path enabled, no events, nothing unmasked
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			enable_q <= `TWAL_CTRL_RST;
			mask_q <= {`TWAL_EVT_W{1'b0}};
			status_q <= {`TWAL_EVT_W{1'b0}};
			count_q <= 32'h0;
		end else begin
			// Acknowledge lasts one cycle
			wb_ack_o <= bus_req;
			// A read clears the status, but an event in the same cycle wins
			status_q <= (rd_status ? {`TWAL_EVT_W{1'b0}} : status_q) | evt;
			// Counts clean completions only
			if (evt[`TWAL_EVT_DONE]) begin
				count_q <= count_q + 32'h1;
			end
			// Register writes; other addresses are acknowledged and ignored
			if (wr_lane0 && wb_adr_i == `TWAL_REG_CTRL) begin
				enable_q <= wb_dat_i[`TWAL_CTRL_EN_BIT];
			// Mask bits follow the status layout
			end else if (wr_lane0 && wb_adr_i == `TWAL_REG_MASK) begin
				mask_q <= wb_dat_i[`TWAL_EVT_W-1:0];
			end
			// Read data; unmapped addresses read as zero
			// Status returns its value from before the clear
			if (bus_req && wb_adr_i == `TWAL_REG_CTRL) begin
				wb_dat_o <= {31'h0, enable_q};
			end else if (bus_req && wb_adr_i == `TWAL_REG_STATUS) begin
				wb_dat_o <= {29'h0, status_q};
			end else if (bus_req && wb_adr_i == `TWAL_REG_MASK) begin
				wb_dat_o <= {29'h0, mask_q};
			end else if (bus_req && wb_adr_i == `TWAL_REG_COUNT) begin
				wb_dat_o <= count_q;
			end else begin
				wb_dat_o <= 32'h0;
			end
		end
	end

	// Level interrupt while any unmasked event is pending
	// Cleared by reading status; the mask only gates the output
	assign irq_o = |(status_q & mask_q);

endmodule // twal_unit

// ==== core/twal_regs.vh ====
/*
 * Constants for the alternate-space twin-word load unit: instruction
 * fields, space identifiers, trap codes and the register map.
 * Assumes a 32-bit instruction word in the usual load/store format.
 */
`ifndef TWAL_REGS_VH
`define TWAL_REGS_VH

// Instruction fields
`define TWAL_OP_HI 31
`define TWAL_OP_LO 30
`define TWAL_OP_MEM 2'h3
`define TWAL_RD_HI 29
`define TWAL_RD_LO 25
`define TWAL_OP3_HI 24
`define TWAL_OP3_LO 19
`define TWAL_OP3_TWIN 6'h13
`define TWAL_RS1_HI 18
`define TWAL_RS1_LO 14
`define TWAL_IBIT 13
`define TWAL_ASI_HI 12
`define TWAL_ASI_LO 5
`define TWAL_RS2_HI 4
`define TWAL_RS2_LO 0
`define TWAL_IMM_HI 12
`define TWAL_IMM_SIGN 12
`define TWAL_IMM_LO 0

// Space identifier checks
`define TWAL_ASI_UNRESTR_BIT 7
`define TWAL_ASI_PRIV_LO 8'h30
`define TWAL_ASI_PRIV_HI 8'h7F
`define TWAL_TWINX_AIUP 8'h22
`define TWAL_TWINX_AIUS 8'h23
`define TWAL_TWINX_ALIAS 8'h24
`define TWAL_TWINX_REAL 8'h26
`define TWAL_TWINX_N 8'h27
`define TWAL_TWINX_P 8'hE2
`define TWAL_TWINX_S 8'hE3

// Alignment of the twin-word access
`define TWAL_ALIGN_BITS 3

// Trap codes
`define TWAL_TRAP_NONE 3'h0
`define TWAL_TRAP_UNIMPL 3'h1
`define TWAL_TRAP_ILLEGAL 3'h2
`define TWAL_TRAP_MISALIGN 3'h3
`define TWAL_TRAP_PRIV 3'h4
`define TWAL_TRAP_DACCESS 3'h5

// Register map (byte addresses)
`define TWAL_REG_CTRL 4'h0
`define TWAL_REG_STATUS 4'h4
`define TWAL_REG_MASK 4'h8
`define TWAL_REG_COUNT 4'hC
`define TWAL_CTRL_RST 1'h1
`define TWAL_CTRL_EN_BIT 0
`define TWAL_EVT_W 3
`define TWAL_EVT_DONE 0
`define TWAL_EVT_TRAP 1
`define TWAL_EVT_REDIR 2

`endif

// ==== sim/twal_unit_assertions.sv ====
/* Port checker for twal_unit, bound to every instance.
   Assumes one clock clk_i and synchronous active-high rst_i. */
`timescale 1ns/1ps
`include "twal_regs.vh"
module twal_chk (
	input wire clk_i,
	input wire rst_i,
	input wire issue_valid_i,
	input wire privilege_state_bit_i,
	input wire issue_ready_o,
	input wire twin_match_o,
	input wire mem_req_o,
	input wire mem_atomic_o,
	input wire mem_ack_i,
	input wire mem_err_i,
	input wire wb_even_we_o,
	input wire wb_odd_we_o,
	input wire trap_valid_o,
	input wire redir_valid_o,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire [31:0] instr_i,
	input wire [63:0] mem_addr_o,
	input wire [63:0] wb_even_data_o,
	input wire [63:0] wb_odd_data_o,
	input wire [7:0] mem_space_o,
	input wire [7:0] redir_space_o,
	input wire [4:0] wb_even_idx_o,
	input wire [4:0] wb_odd_idx_o,
	input wire [2:0] trap_code_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Issue taken by the unit
	sequence s_take;
		issue_valid_i && twin_match_o && issue_ready_o;
	endsequence
	// Memory answers the held request, e gives the error flag
	sequence s_ack(e);
		mem_req_o && mem_ack_i && mem_err_i == e;
	endsequence
	a_take_answer: assert property (s_take |=> $onehot({trap_valid_o, redir_valid_o, mem_req_o}))
		else $error("Issue gave not exactly one answer");
	a_odd_dest: assert property (s_take and instr_i[25] |=> trap_valid_o && trap_code_o inside {3'h1, 3'h2})
		else $error("Odd destination not trapped");
	a_user_space: assert property (s_take and (!instr_i[25] && !privilege_state_bit_i
		&& instr_i[13:12] == 2'h0) |=> trap_valid_o && trap_code_o inside {3'h1, 3'h4})
		else $error("User mode restricted space not trapped");
	a_alias_space: assert property (s_take and (!instr_i[25] && privilege_state_bit_i
		&& instr_i[13:5] == 9'h024) |=> redir_valid_o && redir_space_o == 8'h27 || trap_valid_o && trap_code_o == 3'h1)
		else $error("Alias space not redirected");
	a_no_match: assert property (issue_valid_i && issue_ready_o && !twin_match_o
		|=> !trap_valid_o && !redir_valid_o && !mem_req_o) else $error("Other opcode got an answer");
	a_addr_align: assert property (mem_req_o |-> mem_addr_o[2:0] == 3'h0 && mem_atomic_o)
		else $error("Request misaligned or not atomic");
	a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_space_o))
		else $error("Request dropped or changed before answer");
	a_load_done: assert property (s_ack(1'h0) |=> wb_odd_we_o && wb_odd_idx_o[0] && !mem_req_o)
		else $error("Good answer gave no write-back");
	a_upper_zero: assert property (wb_odd_we_o |-> wb_odd_data_o[63:32] == 0 && (!wb_even_we_o || wb_even_data_o[63:32] == 0))
		else $error("Upper half not cleared");
	a_even_pair: assert property (wb_even_we_o |-> wb_odd_we_o && wb_even_idx_o != 0 && wb_even_idx_o + 5'h1 == wb_odd_idx_o)
		else $error("Even write not paired or register zero written");
	a_err_quiet: assert property (s_ack(1'h1) |=> trap_valid_o && trap_code_o == 3'h5 && !wb_odd_we_o && !wb_even_we_o)
		else $error("Error answer wrote registers");
	a_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus acknowledge not one cycle after request");
endmodule // twal_chk
bind twal_unit twal_chk twal_chk_i (.*);

// ==== sim/twal_mem_model.sv ====
/* Memory path model: answers each held request once, with both words.
   Assumes the request stays up until the edge that sees the answer. */
`timescale 1ns/1ps
module twal_mem_model (
	input wire clk_i,
	input wire rst_i,
	input wire req_i,
	input wire err_cmd_i,
	input wire [1:0] delay_i,
	input wire [63:0] addr_i,
	output reg ack_o,
	output reg err_o,
	output reg [63:0] rdata_o
);
	reg [1:0] wait_q;
	// Word content: derived from its own address
	function [31:0] mw(input [63:0] a);
		mw = {a[15:0], ~a[15:0]};
	endfunction
	// Idle data toggles so a stale sample cannot pass
	always @(posedge clk_i) begin
		ack_o <= 1'h0;
		err_o <= 1'h0;
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			wait_q <= 2'h0;
			rdata_o <= 64'h0;
		end else if (req_i && !ack_o) begin
			if (wait_q == delay_i) begin
				ack_o <= 1'h1;
				err_o <= err_cmd_i;
				rdata_o <= {mw(addr_i), mw(addr_i + 64'h4)};
				wait_q <= 2'h0;
			end else
				wait_q <= wait_q + 2'h1;
		end
	end
endmodule // twal_mem_model

// ==== sim/tb_top.sv ====
/* Self-checking bench for twal_unit against a bench-side reference.
   Assumes twal_unit and twal_mem_model are compiled before it. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_top;
	reg clk_i = 1'h0, rst_i = 1'h1, issue_valid_i = 1'h0, privilege_state_bit_i = 1'h0;
	reg wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, err_q = 1'h0, en = 1'h1;
	reg [31:0] instr_i = 32'h0, wb_dat_i = 32'h0, seed = 32'h0B70B512, d, r;
	reg [63:0] src1_val_i = 64'h0, src2_val_i = 64'h0;
	reg [7:0] space_reg_i = 8'h0;
	reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
	reg [1:0] dly_q = 2'h0;
	integer fails = 0, total_checks = 0, cyc_n = 0, done_n = 0, n;
	logic [7:0] sp_tab [0:3] = '{8'h04, 8'h0C, 8'h80, 8'h88};
	logic [7:0] tw_tab [0:6] = '{8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'hE2, 8'hE3};
	wire issue_ready_o, twin_match_o, mem_req_o, mem_atomic_o, mem_ack_i, mem_err_i, wb_even_we_o;
	wire wb_odd_we_o, trap_valid_o, redir_valid_o, wb_ack_o, irq_o;
	wire [4:0] first_source_field_o, second_source_field_o, wb_even_idx_o, wb_odd_idx_o, redir_rd_o;
	wire [63:0] mem_addr_o, mem_rdata_i, wb_even_data_o, wb_odd_data_o, redir_addr_o;
	wire [7:0] mem_space_o, redir_space_o;
	wire [2:0] trap_code_o;
	wire [31:0] wb_dat_o;
	// Short list: 0C and 88 little-endian
	twal_unit #(.NUM_SPACES(4), .SPACE_LIST(32'h88800C04), .SPACE_LE(4'hA)) twal_unit_i (.*);
	twal_mem_model twal_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o), .err_cmd_i(err_q),
		.delay_i(dly_q), .addr_i(mem_addr_o), .ack_o(mem_ack_i), .err_o(mem_err_i), .rdata_o(mem_rdata_i));
	always #2.5 clk_i = ~clk_i;
	// Hang guard
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			fails++;
			end_of_test;
		end
	end
	function [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		rnd = seed;
	endfunction
	function [31:0] mw(input [63:0] a);
		mw = {a[15:0], ~a[15:0]};
	endfunction
	function [31:0] sw(input [31:0] w);
		sw = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction
	// One classic Wishbone cycle, held until acknowledge
	task wbx(input w, input [3:0] a, input [31:0] wd, output [31:0] rd);
		begin
			@(posedge clk_i);
			wb_cyc_i <= 1'h1;
			wb_stb_i <= 1'h1;
			wb_we_i <= w;
			wb_sel_i <= 4'hF;
			wb_adr_i <= a;
			wb_dat_i <= wd;
			do @(posedge clk_i); while (wb_ack_o !== 1'h1);
			rd = wb_dat_o;
			wb_cyc_i <= 1'h0;
			wb_stb_i <= 1'h0;
		end
	endtask
	// Issue one load and compare with the reference outcome
	task op(input [4:0] rd, input im, input [7:0] sp, input pv, input [63:0] a, b, input er);
		reg [63:0] ea;
		reg [2:0] c;
		reg tw, ok;
		reg [31:0] w0, w1, q;
		integer k;
		begin
			tw = 0;
			ok = 0;
			ea = im ? a + {{51{b[12]}}, b[12:0]} : a + b;
			for (k = 0; k < 7; k++) if (sp == tw_tab[k]) tw = 1;
			for (k = 0; k < 4; k++) if (sp == sp_tab[k]) ok = 1;
			c = !en ? 3'h1 : rd[0] ? 3'h2 : (pv ? sp >= 8'h30 && sp <= 8'h7F : !sp[7]) ? 3'h4 :
				!(ok || tw && !im) ? 3'h5 : tw ? 3'h0 : ea[2:0] ? 3'h3 : er ? 3'h5 : 3'h0;
			@(posedge clk_i);
			issue_valid_i <= 1'h1;
			privilege_state_bit_i <= pv;
			src1_val_i <= a;
			src2_val_i <= b;
			err_q <= er;
			q = rnd();
			dly_q <= q[1:0];
			space_reg_i <= im ? sp : ~sp;
			instr_i <= {2'h3, rd, 6'h13, 5'h1, im, im ? b[12:0] : {sp, 5'h2}};
			@(posedge clk_i);
			issue_valid_i <= 1'h0;
			#1;
			`CHK("match", 1'h1, twin_match_o)
			`CHK("src", {5'h1, im ? b[4:0] : 5'h2}, {first_source_field_o, second_source_field_o})
			for (k = 0; k < 12 && !(trap_valid_o | redir_valid_o | wb_odd_we_o); k++) begin
				if (mem_req_o) `CHK("addr", ea, mem_addr_o)
				if (mem_req_o) `CHK("space", sp, mem_space_o)
				if (mem_req_o) `CHK("busy", 1'h0, issue_ready_o)
				@(posedge clk_i);
				#1;
			end
			`CHK("trap", c != 3'h0, trap_valid_o)
			if (c) `CHK("code", c, trap_code_o)
			`CHK("redir", c == 3'h0 && tw, redir_valid_o)
			if (redir_valid_o) `CHK("rspace", sp == 8'h24 ? 8'h27 : sp, redir_space_o)
			if (redir_valid_o) `CHK("raddr", {rd, ea}, {redir_rd_o, redir_addr_o})
			w0 = mw(ea);
			w1 = mw(ea + 64'h4);
			if (sp == 8'h0C || sp == 8'h88) {w0, w1} = {sw(w0), sw(w1)};
			`CHK("odd_we", c == 3'h0 && !tw, wb_odd_we_o)
			`CHK("even_we", c == 3'h0 && !tw && rd != 5'h0, wb_even_we_o)
			if (wb_odd_we_o) `CHK("odd", {27'h0, rd | 5'h1, 32'h0, w1}, {wb_odd_idx_o, wb_odd_data_o})
			if (wb_even_we_o) `CHK("even", {27'h0, rd, 32'h0, w0}, {wb_even_idx_o, wb_even_data_o})
			if (c == 3'h0 && !tw) done_n++;
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d fails %0d", total_checks, fails);
			if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
			else $display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		wbx(1'h0, 4'h0, 32'h0, d);
		`CHK("ctrl", 32'h1, d)
		wbx(1'h0, 4'h8, 32'h0, d);
		`CHK("mask", 32'h0, d)
		// Another opcode on the issue port must get no answer
		@(posedge clk_i);
		issue_valid_i <= 1'h1;
		instr_i <= {2'h3, 5'h2, 6'h1B, 19'h0};
		@(posedge clk_i);
		issue_valid_i <= 1'h0;
		#1;
		`CHK("nomatch", 4'h0, {twin_match_o, trap_valid_o, redir_valid_o, mem_req_o})
		for (n = 0; n < 40; n++) begin
			r = rnd();
			op({r[4:1], 1'h0}, r[5], sp_tab[r[7:6]], r[8], {rnd(), rnd()} & ~64'h7, {rnd(), rnd()} & ~64'h7, r[9] & r[10]);
		end
		op(5'h0, 1'h1, 8'h88, 1'h1, 64'h100, 64'h1FF8, 1'h0);
		op(5'h3, 1'h0, 8'h80, 1'h1, 64'h0, 64'h0, 1'h0);
		op(5'h2, 1'h0, 8'h04, 1'h0, 64'h0, 64'h0, 1'h0);
		op(5'h2, 1'h0, 8'h30, 1'h1, 64'h0, 64'h0, 1'h0);
		op(5'h2, 1'h0, 8'h7F, 1'h1, 64'h0, 64'h0, 1'h0);
		op(5'h2, 1'h0, 8'h2F, 1'h1, 64'h0, 64'h0, 1'h0);
		op(5'h2, 1'h1, 8'h22, 1'h1, 64'h0, 64'h0, 1'h0);
		op(5'h4, 1'h0, 8'h80, 1'h1, 64'h4, 64'h0, 1'h0);
		op(5'h0, 1'h0, 8'h88, 1'h1, 64'h100, 64'h8, 1'h1);
		for (n = 0; n < 7; n++) op(5'h6, 1'h0, tw_tab[n], 1'h1, 64'h18, 64'h8, 1'h0);
		wbx(1'h1, 4'h0, 32'h0, d);
		en = 1'h0;
		op(5'h2, 1'h0, 8'h80, 1'h1, 64'h0, 64'h0, 1'h0);
		wbx(1'h1, 4'h0, 32'h1, d);
		en = 1'h1;
		wbx(1'h0, 4'h4, 32'h0, d);
		wbx(1'h1, 4'h8, 32'h2, d);
		op(5'h3, 1'h0, 8'h80, 1'h1, 64'h0, 64'h0, 1'h0);
		@(posedge clk_i);
		#1;
		`CHK("irq", 1'h1, irq_o)
		wbx(1'h0, 4'h4, 32'h0, d);
		`CHK("status", 32'h2, d)
		#1;
		`CHK("irq", 1'h0, irq_o)
		wbx(1'h0, 4'hC, 32'h0, d);
		`CHK("count", done_n, d)
		end_of_test;
	end
endmodule // tb_top
